// ==== include/scs_defs.svh ====
// sensor cleaning sequencer: register offsets, reset values, limits, timing counts
// assumes a 100 MHz clock and a 32-bit AXI4-Lite register bus
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define SCS_OFF_CTRL      8'h00
`define SCS_OFF_ANALYSIS  8'h04
`define SCS_OFF_WASH      8'h08
`define SCS_OFF_RINSE     8'h0C
`define SCS_OFF_PAUSE     8'h10
`define SCS_OFF_STATUS    8'h14
`define SCS_OFF_MEAS      8'h18
`define SCS_OFF_START     8'h1C

// ****************************************************************
// control fields
// ****************************************************************
`define SCS_CTRL_ENABLE   0
`define SCS_CTRL_VARIANT  1
`define SCS_CTRL_CONTROL  2

// ****************************************************************
// status fields
// ****************************************************************
`define SCS_STAT_PHASE_LSB 0
`define SCS_STAT_PHASE_MSB 3
`define SCS_STAT_CNT_LSB   8
`define SCS_STAT_CNT_MSB   24

// ****************************************************************
// widths, limits and reset values (durations in seconds)
// ****************************************************************
`define SCS_ANA_W         17
`define SCS_PH_W          11
`define SCS_MEAS_W        16
`define SCS_ANA_MIN       17'd1
`define SCS_ANA_MAX       17'd108000
`define SCS_PH_MAX        11'd1800
`define SCS_ANA_RST       17'd84600
`define SCS_PH_RST        11'd600

// ****************************************************************
// time base
// ****************************************************************
`define SCS_CLK_HZ        100000000
`define SCS_TICK_S        1
`define SCS_TICK_CYCLES   (`SCS_CLK_HZ * `SCS_TICK_S)

`endif

// ==== include/scs_pkg.sv ====
// sensor cleaning sequencer: shared types
// assumes nothing beyond the constants header
package scs_pkg;

    typedef enum logic [3:0] {
        SCS_ANALYSIS = 4'h1,
        SCS_WASHING  = 4'h2,
        SCS_RINSING  = 4'h4,
        SCS_PAUSE    = 4'h8
    } scs_phase_type;

    typedef logic [1:0] scs_resp_type;

endpackage

// ==== src/scs_sequencer.sv ====
// sensor cleaning sequencer with AXI4-Lite register slave
// assumes all inputs synchronous to clk, one master, one write and one read at a time
//
// Notes on behaviour
// [RQ1] an enable bit turns cleaning on or off; it resets to off
// [RQ2] when enabled, the sequence runs and drives wash and rinse valve relays
// [RQ3] phases go analysis, washing, rinsing, pause, analysis, each its own duration
// [RQ4] analysis duration accepted from 1 s to 30 h, default 23.5 h
// [RQ5] washing duration accepted from 0 to 30 min, default 10 min
// [RQ6] rinsing duration accepted from 0 to 30 min, default 10 min
// [RQ7] pause duration accepted from 0 to 30 min, default 10 min
// [RQ8] relays closed except wash open in washing, rinse open in rinsing; banner otherwise; code raises clean_banner in washing, rinsing and pause, not analysis
// [RQ9] reported measurement holds the last valid value while cleaning is active
// [RQ10] in controller operation, manual mode is forced while cleaning is active
// [RQ11] the operator may start a cycle at once with the cleaning key
// [RQ12] automatic start when analysis duration expires after previous cycle end
// [RQ13] two selectable sequence variants, analytic unit or sequential cleaning unit; the bit only drives variant_b, same phases for both
// [RQ14] a zero-duration phase is skipped at the next second tick
// [RQ15] a start request during washing, rinsing or pause is ignored
`include "scs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module scs_sequencer
    import scs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `SCS_TICK_CYCLES
)
(
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output var  logic                   s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output var  logic                   s_axi_wready,
    output var  logic [1:0]             s_axi_bresp,
    output var  logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output var  logic                   s_axi_arready,
    output var  logic [31:0]            s_axi_rdata,
    output var  logic [1:0]             s_axi_rresp,
    output var  logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   clean_key,
    input  wire logic [`SCS_MEAS_W-1:0] meas_in,
    input  wire logic                   meas_valid,
    output var  logic [`SCS_MEAS_W-1:0] meas_out,
    output var  logic                   wash_valve_relay,
    output var  logic                   rinse_valve_relay,
    output var  logic                   clean_banner,
    output var  logic                   force_manual,
    output var  logic                   variant_b
);

    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [`SCS_PH_W-1:0] clamp_ph(input logic [31:0] v);
        return (v > 32'(`SCS_PH_MAX)) ? `SCS_PH_MAX : v[`SCS_PH_W-1:0];
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a <= `SCS_OFF_START) && (a[1:0] == 2'b00);
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic [2:0]              ctrl_q, ctrl_d;
    logic [`SCS_ANA_W-1:0]   ana_q, ana_d;
    logic [`SCS_PH_W-1:0]    wash_q, wash_d, rinse_q, rinse_d, pause_q, pause_d;
    scs_phase_type           phase_q, phase_d;
    logic [`SCS_ANA_W-1:0]   sec_q, sec_d;
    logic [31:0]             tick_q, tick_d;
    logic [`SCS_MEAS_W-1:0]  meas_q, meas_d;
    logic                    aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0]              awaddr_q, awaddr_d;
    logic [31:0]             wdata_q, wdata_d;
    logic [3:0]              wstrb_q, wstrb_d;
    logic                    bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    scs_resp_type            bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]             rdata_q, rdata_d;
    logic                    sw_start;

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb
    begin
        logic [31:0]           nv;
        logic [`SCS_ANA_W-1:0] dur;
        logic                  tick;
        logic                  do_wr;
        nv        = 32'h0;
        dur       = '0;
        tick      = 1'b0;
        do_wr     = 1'b0;
        ctrl_d    = ctrl_q;
        ana_d     = ana_q;
        wash_d    = wash_q;
        rinse_d   = rinse_q;
        pause_d   = pause_q;
        phase_d   = phase_q;
        sec_d     = sec_q;
        meas_d    = meas_q;
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        sw_start  = 1'b0;

        // write channel: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        do_wr = aw_have_q && w_have_q && !bvalid_q;
        if (do_wr)
        begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = mapped(awaddr_q) ? 2'b00 : 2'b11;
            case (awaddr_q)
                `SCS_OFF_CTRL:
                begin
                    nv     = merge_bytes({29'h0, ctrl_q}, wdata_q, wstrb_q);
                    ctrl_d = nv[2:0]; // RQ1 RQ13
                end
                `SCS_OFF_ANALYSIS:
                begin
                    nv = merge_bytes({15'h0, ana_q}, wdata_q, wstrb_q);
                    if (nv > 32'(`SCS_ANA_MAX))
                        ana_d = `SCS_ANA_MAX; // RQ4
                    else if (nv < 32'(`SCS_ANA_MIN))
                        ana_d = `SCS_ANA_MIN; // RQ4
                    else
                        ana_d = nv[`SCS_ANA_W-1:0];
                end
                `SCS_OFF_WASH:  wash_d  = clamp_ph(merge_bytes({21'h0, wash_q}, wdata_q, wstrb_q)); // RQ5
                `SCS_OFF_RINSE: rinse_d = clamp_ph(merge_bytes({21'h0, rinse_q}, wdata_q, wstrb_q)); // RQ6
                `SCS_OFF_PAUSE: pause_d = clamp_ph(merge_bytes({21'h0, pause_q}, wdata_q, wstrb_q)); // RQ7
                `SCS_OFF_START: sw_start = wstrb_q[0] && wdata_q[0];
                default: ;
            endcase
        end
        if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end

        // read channel: one-cycle answer after the address is taken
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_d = 1'b1;
            rresp_d  = mapped(s_axi_araddr) ? 2'b00 : 2'b11;
            case (s_axi_araddr)
                `SCS_OFF_CTRL:     rdata_d = {29'h0, ctrl_q};
                `SCS_OFF_ANALYSIS: rdata_d = {15'h0, ana_q};
                `SCS_OFF_WASH:     rdata_d = {21'h0, wash_q};
                `SCS_OFF_RINSE:    rdata_d = {21'h0, rinse_q};
                `SCS_OFF_PAUSE:    rdata_d = {21'h0, pause_q};
                `SCS_OFF_STATUS:   rdata_d = {7'h0, sec_q, 4'h0, phase_q};
                `SCS_OFF_MEAS:     rdata_d = {16'h0, meas_q};
                default:           rdata_d = 32'h0;
            endcase
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end

        // one-second time base
        tick   = (tick_q == TICK_CYCLES - 1);
        tick_d = tick ? 32'h0 : tick_q + 32'h1;

        // phase sequencing
        case (phase_q)
            SCS_ANALYSIS: dur = ana_q;
            SCS_WASHING:  dur = {6'h0, wash_q};
            SCS_RINSING:  dur = {6'h0, rinse_q};
            SCS_PAUSE:    dur = {6'h0, pause_q};
            default:      dur = '0;
        endcase
        if (!ctrl_q[`SCS_CTRL_ENABLE])
        begin
            phase_d = SCS_ANALYSIS; // RQ1
            sec_d   = '0;
        end
        else if (phase_q == SCS_ANALYSIS && (clean_key || sw_start))
        begin
            phase_d = SCS_WASHING; // RQ11 RQ15
            sec_d   = '0;
        end
        else if (tick)
        begin
            // clean_key outside analysis falls through here unused
            if (dur == '0 || sec_q + 1'b1 >= dur) // RQ14
            begin
                sec_d = '0;
                case (phase_q) // RQ2 RQ3 RQ12
                    SCS_ANALYSIS: phase_d = SCS_WASHING;
                    SCS_WASHING:  phase_d = SCS_RINSING;
                    SCS_RINSING:  phase_d = SCS_PAUSE;
                    SCS_PAUSE:    phase_d = SCS_ANALYSIS;
                    default:      phase_d = SCS_ANALYSIS;
                endcase
            end
            else
            begin
                sec_d = sec_q + 1'b1;
            end
        end

        // measurement freeze
        if (phase_d == SCS_ANALYSIS && meas_valid)
        begin
            meas_d = meas_in; // RQ9
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_q            <= 3'h0;
            ana_q             <= `SCS_ANA_RST;
            wash_q            <= `SCS_PH_RST;
            rinse_q           <= `SCS_PH_RST;
            pause_q           <= `SCS_PH_RST;
            phase_q           <= SCS_ANALYSIS;
            sec_q             <= '0;
            tick_q            <= 32'h0;
            meas_q            <= '0;
            aw_have_q         <= 1'b0;
            w_have_q          <= 1'b0;
            awaddr_q          <= 8'h00;
            wdata_q           <= 32'h0;
            wstrb_q           <= 4'h0;
            bvalid_q          <= 1'b0;
            bresp_q           <= 2'b00;
            rvalid_q          <= 1'b0;
            rresp_q           <= 2'b00;
            rdata_q           <= 32'h0;
            s_axi_awready     <= 1'b0;
            s_axi_wready      <= 1'b0;
            s_axi_arready     <= 1'b0;
            meas_out          <= '0;
            wash_valve_relay  <= 1'b1;
            rinse_valve_relay <= 1'b1;
            clean_banner      <= 1'b0;
            force_manual      <= 1'b0;
            variant_b         <= 1'b0;
        end
        else
        begin
            ctrl_q            <= ctrl_d;
            ana_q             <= ana_d;
            wash_q            <= wash_d;
            rinse_q           <= rinse_d;
            pause_q           <= pause_d;
            phase_q           <= phase_d;
            sec_q             <= sec_d;
            tick_q            <= tick_d;
            meas_q            <= meas_d;
            aw_have_q         <= aw_have_d;
            w_have_q          <= w_have_d;
            awaddr_q          <= awaddr_d;
            wdata_q           <= wdata_d;
            wstrb_q           <= wstrb_d;
            bvalid_q          <= bvalid_d;
            bresp_q           <= bresp_d;
            rvalid_q          <= rvalid_d;
            rresp_q           <= rresp_d;
            rdata_q           <= rdata_d;
            s_axi_awready     <= !aw_have_d;
            s_axi_wready      <= !w_have_d;
            s_axi_arready     <= !rvalid_d;
            meas_out          <= meas_d; // RQ9
            wash_valve_relay  <= (phase_d != SCS_WASHING); // RQ8
            rinse_valve_relay <= (phase_d != SCS_RINSING); // RQ8
            clean_banner      <= (phase_d != SCS_ANALYSIS); // RQ8
            force_manual      <= (phase_d != SCS_ANALYSIS) && ctrl_d[`SCS_CTRL_CONTROL]; // RQ10
            variant_b         <= ctrl_d[`SCS_CTRL_VARIANT]; // RQ13
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = rdata_q;

endmodule // scs_sequencer

`default_nettype wire

// ==== verif/scs_sequencer_checker.sv ====
// checker: relay, banner and freeze relations at the sequencer ports
// assumes it is bound to scs_sequencer, everything on clk with srst
`include "scs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module scs_sequencer_checker
#(
    parameter int unsigned TICK_CYCLES = 10
)
(
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic [`SCS_MEAS_W-1:0] meas_out,
    input  wire logic                   wash_valve_relay,
    input  wire logic                   rinse_valve_relay,
    input  wire logic                   clean_banner,
    input  wire logic                   force_manual,
    input  wire logic                   variant_b
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_wash;
        !wash_valve_relay && rinse_valve_relay && clean_banner;
    endsequence
    sequence s_rinse;
        wash_valve_relay && !rinse_valve_relay && clean_banner;
    endsequence

    property p_wash_relays;
        !wash_valve_relay |-> s_wash;
    endproperty
    property p_rinse_relays;
        !rinse_valve_relay |-> s_rinse;
    endproperty
    property p_start_wash;
        $rose(clean_banner) |-> s_wash;
    endproperty
    property p_wash_next;
        $rose(wash_valve_relay) && clean_banner |-> s_rinse;
    endproperty
    property p_rinse_entry;
        $fell(rinse_valve_relay) |-> !$past(wash_valve_relay);
    endproperty
    property p_no_restart;
        $fell(wash_valve_relay) |-> !$past(clean_banner);
    endproperty
    property p_freeze;
        clean_banner |-> $stable(meas_out);
    endproperty
    property p_manual;
        force_manual |-> clean_banner;
    endproperty
    property p_reset;
        disable iff (1'b0) srst |=> wash_valve_relay && rinse_valve_relay
            && !clean_banner && !force_manual && !variant_b;
    endproperty

    a_wash_relays: assert property (p_wash_relays) else $error("wash relay open outside washing");
    a_rinse_relays: assert property (p_rinse_relays) else $error("rinse relay open outside rinsing");
    a_start_wash: assert property (p_start_wash) else $error("cleaning did not start with washing");
    a_wash_next: assert property (p_wash_next) else $error("washing not followed by rinsing");
    a_rinse_entry: assert property (p_rinse_entry) else $error("rinsing entered not from washing");
    a_no_restart: assert property (p_no_restart) else $error("washing restarted inside a cycle");
    a_freeze: assert property (p_freeze) else $error("measurement moved while cleaning");
    a_manual: assert property (p_manual) else $error("manual forced outside cleaning");
    a_reset: assert property (p_reset) else $error("outputs wrong after reset");
endmodule // scs_sequencer_checker

bind scs_sequencer scs_sequencer_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk(clk), .srst(srst),
    .meas_out(meas_out), .wash_valve_relay(wash_valve_relay), .rinse_valve_relay(rinse_valve_relay),
    .clean_banner(clean_banner), .force_manual(force_manual), .variant_b(variant_b));
`default_nettype wire

// ==== verif/scs_valve_model.sv ====
// solenoid valve pair switched by the wash and rinse relay contacts
// assumes relay high is a closed contact; a line flows while its contact is open
`timescale 1ns/1ps
`default_nettype none

module scs_valve_model
(
    input  wire logic clk,
    input  wire logic wash_valve_relay,
    input  wire logic rinse_valve_relay,
    output var  logic wash_flow,
    output var  logic rinse_flow
);
    // ****************************************************************
    // valve response, one clock behind the contact
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        wash_flow  <= !wash_valve_relay;
        rinse_flow <= !rinse_valve_relay;
    end
endmodule // scs_valve_model
`default_nettype wire

// ==== verif/tb_scs_sequencer.sv ====
// testbench: bus access, phase timing, freeze and start checks of the sequencer
// assumes a tick of ten clocks, so each second of duration is ten cycles
`include "scs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_scs_sequencer;
    localparam int TK = 10;
    logic        clk = 1'b0, srst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        clean_key = 1'b0, meas_valid = 1'b1;
    logic [15:0] meas_in = 16'h1234, meas_out;
    logic        wash_valve_relay, rinse_valve_relay, clean_banner, force_manual, variant_b;
    logic        wash_flow, rinse_flow;
    logic [2:0]  st;
    int          err_count = 0, tests_run = 0, n;

    assign st = {clean_banner, wash_valve_relay, rinse_valve_relay};
    always #5 clk = ~clk;
    scs_sequencer #(.TICK_CYCLES(TK)) dut_u (
        .clk               (clk),
        .srst              (srst),
        .s_axi_awaddr      (s_axi_awaddr),
        .s_axi_awvalid     (s_axi_awvalid),
        .s_axi_awready     (s_axi_awready),
        .s_axi_wdata       (s_axi_wdata),
        .s_axi_wstrb       (s_axi_wstrb),
        .s_axi_wvalid      (s_axi_wvalid),
        .s_axi_wready      (s_axi_wready),
        .s_axi_bresp       (s_axi_bresp),
        .s_axi_bvalid      (s_axi_bvalid),
        .s_axi_bready      (s_axi_bready),
        .s_axi_araddr      (s_axi_araddr),
        .s_axi_arvalid     (s_axi_arvalid),
        .s_axi_arready     (s_axi_arready),
        .s_axi_rdata       (s_axi_rdata),
        .s_axi_rresp       (s_axi_rresp),
        .s_axi_rvalid      (s_axi_rvalid),
        .s_axi_rready      (s_axi_rready),
        .clean_key         (clean_key),
        .meas_in           (meas_in),
        .meas_valid        (meas_valid),
        .meas_out          (meas_out),
        .wash_valve_relay  (wash_valve_relay),
        .rinse_valve_relay (rinse_valve_relay),
        .clean_banner      (clean_banner),
        .force_manual      (force_manual),
        .variant_b         (variant_b)
    );
    scs_valve_model valve_u (
        .clk               (clk),
        .wash_valve_relay  (wash_valve_relay),
        .rinse_valve_relay (rinse_valve_relay),
        .wash_flow         (wash_flow),
        .rinse_flow        (rinse_flow)
    );

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, r});
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_st(input logic [2:0] s);
        while (st !== s) @(posedge clk);
    endtask
    // counts the cycles the current phase outputs stay unchanged
    task automatic hold(output int k);
        logic [2:0] s0;
        s0 = st;
        k = 0;
        while (st === s0)
        begin
            @(posedge clk);
            k++;
        end
    endtask

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial
    begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(st, 3'h3);
        rc(`SCS_OFF_CTRL, 32'h0, 2'h0);
        rc(`SCS_OFF_ANALYSIS, 32'h14A78, 2'h0);
        rc(`SCS_OFF_WASH, 32'h258, 2'h0);
        rc(`SCS_OFF_RINSE, 32'h258, 2'h0);
        rc(`SCS_OFF_PAUSE, 32'h258, 2'h0);
        rc(8'h20, 32'h0, 2'h3);
        wr(8'h20, 32'h7, 2'h3);
        rc(`SCS_OFF_CTRL, 32'h0, 2'h0);
        rc(`SCS_OFF_MEAS, 32'h1234, 2'h0);
        wr(`SCS_OFF_ANALYSIS, 32'h0);
        rc(`SCS_OFF_ANALYSIS, 32'h1, 2'h0);
        wr(`SCS_OFF_ANALYSIS, 32'h30D40);
        rc(`SCS_OFF_ANALYSIS, 32'h1A5E0, 2'h0);
        wr(`SCS_OFF_WASH, 32'hFFFF);
        rc(`SCS_OFF_WASH, 32'h708, 2'h0);
        wr(`SCS_OFF_RINSE, 32'h709);
        rc(`SCS_OFF_RINSE, 32'h708, 2'h0);
        wr(`SCS_OFF_PAUSE, 32'h708);
        rc(`SCS_OFF_PAUSE, 32'h708, 2'h0);
        wr(`SCS_OFF_ANALYSIS, 32'h3);
        wr(`SCS_OFF_WASH, 32'h2);
        wr(`SCS_OFF_RINSE, 32'h0);
        wr(`SCS_OFF_PAUSE, 32'h1);
        clean_key <= 1'b1;
        repeat (3) @(posedge clk);
        clean_key <= 1'b0;
        chk(st, 3'h3);
        wr(`SCS_OFF_CTRL, 32'h7);
        chk(variant_b, 1'b1);
        chk(meas_out, 16'h1234);
        clean_key <= 1'b1;
        wait_st(3'h5);
        clean_key <= 1'b0;
        chk(force_manual, 1'b1);
        meas_in <= 16'h5678;
        repeat (3) @(posedge clk);
        chk(meas_out, 16'h1234);
        chk(wash_flow, 1'b1);
        wait_st(3'h6);
        clean_key <= 1'b1;
        @(posedge clk);
        clean_key <= 1'b0;
        hold(n);
        chk(n + 1, TK);
        hold(n);
        chk(n, TK);
        hold(n);
        chk(n, 3 * TK);
        chk(meas_out, 16'h5678);
        hold(n);
        chk(n, 2 * TK);
        chk(st, 3'h6);
        wr(`SCS_OFF_CTRL, 32'h0);
        chk(st, 3'h3);
        chk(variant_b, 1'b0);
        wr(`SCS_OFF_CTRL, 32'h1);
        wr(`SCS_OFF_START, 32'h1);
        chk(st, 3'h5);
        chk(force_manual, 1'b0);
        give_verdict;
    end

    initial
    begin
        #200000;
        err_count++;
        give_verdict;
    end
endmodule // tb_scs_sequencer
`default_nettype wire
